// >>> hdl/mppl_top.sv
// lower-threshold config for internal channels 6-8 and post-processing start-up control
//
// Notes on behaviour
// R1: hysteresis select maps to off, 4, 8, 16
// R2: debounce select maps to 1..128 measurements
// R3: channel 8 fields at bits 20:19, 18:16
// R4: channel 7 at 12:11, 10:8; 15:13 zero
// R5: channel 6 at 4:3, 2:0; 7:5 zero
// R6: status outputs forced low during start-up
// R7: ready low in start-up, high after
// R8: start-up lasts 2200 end-of-conversion events
// R9: filter coefficient forced to 2^-1 in start-up
// R10: channel sequence forced to all ones in start-up
// R11: internal channel fields writable only when unlocked
// R12: after ready, programmed settings and status pass
`timescale 1ns/1ps
module mppl_top (
   // clock and reset
   input  wire logic                    MCLK_IN,
   input  wire logic                    RESETN_IN,
   // converter side
   input  wire logic                    EOC_IN,
   input  wire logic [7:0]              STATUS_IN,
   // axi4-lite write address
   input  wire logic                    AXI_AWVALID_IN,
   output logic                         AXI_AWREADY_OUT,
   input  wire logic [7:0]              AXI_AWADDR_IN,
   // axi4-lite write data
   input  wire logic                    AXI_WVALID_IN,
   output logic                         AXI_WREADY_OUT,
   input  wire logic [31:0]             AXI_WDATA_IN,
   input  wire logic [3:0]              AXI_WSTRB_IN,
   // axi4-lite write response
   output logic                         AXI_BVALID_OUT,
   input  wire logic                    AXI_BREADY_IN,
   output logic [1:0]                   AXI_BRESP_OUT,
   // axi4-lite read
   input  wire logic                    AXI_ARVALID_IN,
   output logic                         AXI_ARREADY_OUT,
   input  wire logic [7:0]              AXI_ARADDR_IN,
   output logic                         AXI_RVALID_OUT,
   input  wire logic                    AXI_RREADY_IN,
   output logic [31:0]                  AXI_RDATA_OUT,
   output logic [1:0]                   AXI_RRESP_OUT,
   // post-processing outputs
   output logic                         CORE_READY_OUT,
   output logic [7:0]                   STATUS_OUT,
   output mppl_pkg::mppl_acq_cfg_t      ACQ_CFG_OUT,
   output mppl_pkg::mppl_chan_thr_t     CH6_THR_OUT,
   output mppl_pkg::mppl_chan_thr_t     CH7_THR_OUT,
   output mppl_pkg::mppl_chan_thr_t     CH8_THR_OUT
);

   typedef enum logic [1:0] {
      ST_STARTUP = 2'b01,
      ST_RUN     = 2'b10
   } mppl_state_t;

   mppl_state_t   state;
   logic [11:0]   eoc_cnt;
   logic [31:0]   lowcfg;
   logic [9:0]    seq_cfg;
   logic [1:0]    coef_cfg;
   logic          unlocked;
   logic [7:0]    aw_addr;
   logic [31:0]   w_data;
   logic [3:0]    w_strb;
   logic          wr_commit;
   logic [31:0]   rd_word;

   // address decode shared by the read and write paths
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == mppl_pkg::SEQ_CFG_ADDR) || (a == mppl_pkg::FILT_CFG_ADDR) ||
                  (a == mppl_pkg::CORE_STAT_ADDR) || (a == mppl_pkg::ACCESS_ADDR) ||
                  (a == mppl_pkg::LOWCFG_ADDR);
   endfunction

   // a write commits once address and data are both held and no response is pending
   assign wr_commit = !AXI_AWREADY_OUT && !AXI_WREADY_OUT && !AXI_BVALID_OUT;

   // write address channel: ready is the free flag itself
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         AXI_AWREADY_OUT <= 1'b1;
         aw_addr         <= 8'h00;
      end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
         AXI_AWREADY_OUT <= 1'b0;
         aw_addr         <= AXI_AWADDR_IN;
      end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
         AXI_AWREADY_OUT <= 1'b1;
      end
   end

   // write data channel, taken independently of the address
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         AXI_WREADY_OUT <= 1'b1;
         w_data         <= 32'h0000_0000;
         w_strb         <= 4'h0;
      end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
         AXI_WREADY_OUT <= 1'b0;
         w_data         <= AXI_WDATA_IN;
         w_strb         <= AXI_WSTRB_IN;
      end else if (AXI_BVALID_OUT && AXI_BREADY_IN) begin
         AXI_WREADY_OUT <= 1'b1;
      end
   end

   // write response; protected or unmapped writes answer slverr and change nothing
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         AXI_BVALID_OUT <= 1'b0;
         AXI_BRESP_OUT  <= mppl_pkg::RESP_OKAY;
      end else if (wr_commit) begin
         AXI_BVALID_OUT <= 1'b1;
         AXI_BRESP_OUT  <= (!is_mapped(aw_addr) || (aw_addr == mppl_pkg::CORE_STAT_ADDR) ||
                            (aw_addr == mppl_pkg::LOWCFG_ADDR && !unlocked)) ?
                           mppl_pkg::RESP_SLVERR : mppl_pkg::RESP_OKAY;
      end else if (AXI_BREADY_IN) begin
         AXI_BVALID_OUT <= 1'b0;
      end
   end

   // lower-threshold config word; reserved bits are masked so they always read zero
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         lowcfg <= mppl_pkg::LOWCFG_RESET;
      end else if (wr_commit && aw_addr == mppl_pkg::LOWCFG_ADDR && unlocked) begin // see R11
         lowcfg <= mppl_pkg::apply_strb(lowcfg, w_data, w_strb) & mppl_pkg::LOWCFG_MASK; // see R4 see R5
      end
   end

   // programmed sequence, coefficient and the unlock bit guarding the internal channels
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         seq_cfg  <= mppl_pkg::SEQ_RESET;
         coef_cfg <= mppl_pkg::COEF_RESET;
         unlocked <= mppl_pkg::UNLOCK_RESET;
      end else if (wr_commit) begin
         unique case (aw_addr)
            mppl_pkg::SEQ_CFG_ADDR: begin
               seq_cfg <= 10'(mppl_pkg::apply_strb({22'h0, seq_cfg}, w_data, w_strb)); // keep the field bits only
            end
            mppl_pkg::FILT_CFG_ADDR: begin
               coef_cfg <= 2'(mppl_pkg::apply_strb({30'h0, coef_cfg}, w_data, w_strb));
            end
            mppl_pkg::ACCESS_ADDR: begin
               unlocked <= 1'(mppl_pkg::apply_strb({31'h0, unlocked}, w_data, w_strb));
            end
            default: begin
            end
         endcase
      end
   end

   // read data mux
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (AXI_ARADDR_IN)
         mppl_pkg::SEQ_CFG_ADDR:   rd_word = {22'h0, seq_cfg};
         mppl_pkg::FILT_CFG_ADDR:  rd_word = {30'h0, coef_cfg};
         mppl_pkg::CORE_STAT_ADDR: rd_word = {19'h0, eoc_cnt, CORE_READY_OUT};
         mppl_pkg::ACCESS_ADDR:    rd_word = {31'h0, unlocked};
         mppl_pkg::LOWCFG_ADDR:    rd_word = lowcfg;
         default:                  rd_word = 32'h0000_0000;
      endcase
   end

   // read channel: one answer per request, data held until taken
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         AXI_ARREADY_OUT <= 1'b1;
         AXI_RVALID_OUT  <= 1'b0;
         AXI_RDATA_OUT   <= 32'h0000_0000;
         AXI_RRESP_OUT   <= mppl_pkg::RESP_OKAY;
      end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
         AXI_ARREADY_OUT <= 1'b0;
         AXI_RVALID_OUT  <= 1'b1;
         AXI_RDATA_OUT   <= rd_word;
         AXI_RRESP_OUT   <= is_mapped(AXI_ARADDR_IN) ? mppl_pkg::RESP_OKAY : mppl_pkg::RESP_SLVERR;
      end else if (AXI_RVALID_OUT && AXI_RREADY_IN) begin
         AXI_ARREADY_OUT <= 1'b1;
         AXI_RVALID_OUT  <= 1'b0;
      end
   end

   // start-up sequencing counts conversions, not clocks, since settling tracks the converter
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         state          <= ST_STARTUP;
         eoc_cnt        <= 12'h000;
         CORE_READY_OUT <= 1'b0;
      end else begin
         unique case (state)
            ST_STARTUP: begin
               if (EOC_IN) begin
                  eoc_cnt <= eoc_cnt + 12'h001; // see R8
                  if (eoc_cnt == mppl_pkg::STARTUP_EOCS - 12'h001) begin
                     state          <= ST_RUN;
                     CORE_READY_OUT <= 1'b1; // see R7
                  end
               end
            end
            ST_RUN: begin
               CORE_READY_OUT <= 1'b1;
            end
         endcase
      end
   end

   // status and acquisition settings; the run switch lags ready by one edge
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         STATUS_OUT  <= 8'h00;
         ACQ_CFG_OUT <= '{seq: mppl_pkg::FORCED_SEQ, coef: mppl_pkg::FASTEST_COEF};
      end else if (state == ST_RUN) begin
         STATUS_OUT  <= STATUS_IN; // see R12
         ACQ_CFG_OUT <= '{seq: seq_cfg, coef: coef_cfg}; // see R12
      end else begin
         STATUS_OUT  <= 8'h00; // see R6
         ACQ_CFG_OUT <= '{seq: mppl_pkg::FORCED_SEQ, coef: mppl_pkg::FASTEST_COEF}; // see R9 see R10
      end
   end

   // decoded per-channel lower-threshold settings
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         CH6_THR_OUT <= '{hysteresis: 5'h00, debounce: 8'h01};
         CH7_THR_OUT <= '{hysteresis: 5'h00, debounce: 8'h01};
         CH8_THR_OUT <= '{hysteresis: 5'h00, debounce: 8'h01};
      end else begin
         CH6_THR_OUT <= '{hysteresis: mppl_pkg::hyst_value(lowcfg[mppl_pkg::CH6_HYST_LSB +: 2]), // see R5 see R1
                          debounce: mppl_pkg::debounce_count(lowcfg[mppl_pkg::CH6_CNT_LSB +: 3])}; // see R2
         CH7_THR_OUT <= '{hysteresis: mppl_pkg::hyst_value(lowcfg[mppl_pkg::CH7_HYST_LSB +: 2]), // see R4
                          debounce: mppl_pkg::debounce_count(lowcfg[mppl_pkg::CH7_CNT_LSB +: 3])};
         CH8_THR_OUT <= '{hysteresis: mppl_pkg::hyst_value(lowcfg[mppl_pkg::CH8_HYST_LSB +: 2]), // see R3
                          debounce: mppl_pkg::debounce_count(lowcfg[mppl_pkg::CH8_CNT_LSB +: 3])};
      end
   end

   // checks
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RESETN_IN);
   // an attempt on the release edge still sees reset sampled low, so antecedents test RESETN_IN
   // decode checks look one edge back because the outputs lag the config word by a register

   chk_hyst_decode: assert property ( // see R1
      ##1 (lowcfg[mppl_pkg::CH6_HYST_LSB +: 2] == $past(lowcfg[mppl_pkg::CH6_HYST_LSB +: 2])) |=>
      CH6_THR_OUT.hysteresis == (($past(lowcfg[4:3]) == 2'h0) ? 5'h00 : (5'h02 << $past(lowcfg[4:3]))))
      else $error("channel 6 hysteresis decode wrong");

   chk_debounce_decode: assert property ( // see R2
      RESETN_IN && $stable(lowcfg) |=> (CH7_THR_OUT.debounce == (8'h01 << $past(lowcfg[10:8]))))
      else $error("channel 7 debounce decode wrong");

   chk_ch8_fields: assert property ( // see R3
      RESETN_IN && $stable(lowcfg) |=> (CH8_THR_OUT.debounce == (8'h01 << $past(lowcfg[18:16]))) &&
                          (CH8_THR_OUT.hysteresis[4] == ($past(lowcfg[20:19]) == 2'h3)))
      else $error("channel 8 field position wrong");

   chk_reserved_zero: assert property ( // see R4
      RESETN_IN && AXI_ARVALID_IN && AXI_ARREADY_OUT && (AXI_ARADDR_IN == mppl_pkg::LOWCFG_ADDR) |=>
      (AXI_RDATA_OUT[15:13] == 3'h0) && (AXI_RDATA_OUT[7:5] == 3'h0) && (AXI_RDATA_OUT[31:21] == 11'h000))
      else $error("reserved bits read nonzero");

   chk_reserved_store: assert property ( // see R5
      (lowcfg & ~mppl_pkg::LOWCFG_MASK) == 32'h0000_0000)
      else $error("reserved bits stored");

   chk_status_held: assert property ( // see R6
      !CORE_READY_OUT |=> STATUS_OUT == 8'h00)
      else $error("status leaked during start-up");

   chk_ready_sticky: assert property ( // see R7
      CORE_READY_OUT |=> CORE_READY_OUT)
      else $error("ready dropped without reset");

   chk_ready_count: assert property ( // see R8
      $rose(CORE_READY_OUT) |-> (eoc_cnt == mppl_pkg::STARTUP_EOCS) && $past(EOC_IN))
      else $error("ready not at 2200 events");

   chk_early_ready: assert property ( // see R8
      (eoc_cnt < mppl_pkg::STARTUP_EOCS) |-> !CORE_READY_OUT)
      else $error("ready before start-up done");

   chk_coef_forced: assert property ( // see R9
      !CORE_READY_OUT |=> ACQ_CFG_OUT.coef == mppl_pkg::FASTEST_COEF)
      else $error("coefficient not forced");

   chk_seq_forced: assert property ( // see R10
      !CORE_READY_OUT |=> ACQ_CFG_OUT.seq == mppl_pkg::FORCED_SEQ)
      else $error("sequence not forced");

   chk_locked_write: assert property ( // see R11
      (wr_commit && aw_addr == mppl_pkg::LOWCFG_ADDR && !unlocked) |=>
      $stable(lowcfg) && AXI_BVALID_OUT && (AXI_BRESP_OUT == mppl_pkg::RESP_SLVERR))
      else $error("locked write changed config");

   chk_run_programmed: assert property ( // see R12
      CORE_READY_OUT ##1 CORE_READY_OUT |-> (ACQ_CFG_OUT.seq == $past(seq_cfg)) &&
                                            (STATUS_OUT == $past(STATUS_IN)))
      else $error("programmed settings not used after ready");

   chk_run_coef: assert property ( // see R12
      CORE_READY_OUT ##1 CORE_READY_OUT |-> ACQ_CFG_OUT.coef == $past(coef_cfg))
      else $error("programmed coefficient not used after ready");

   chk_ready_needs_event: assert property ( // see R8
      !CORE_READY_OUT && !EOC_IN |=> !CORE_READY_OUT)
      else $error("ready rose without a conversion event");

   chk_ch6_debounce: assert property ( // see R2
      RESETN_IN && $stable(lowcfg) |=> (CH6_THR_OUT.debounce == (8'h01 << $past(lowcfg[2:0]))))
      else $error("channel 6 debounce decode wrong");

   chk_ch7_hysteresis: assert property ( // see R4
      RESETN_IN && $stable(lowcfg) |=>
      CH7_THR_OUT.hysteresis == (($past(lowcfg[12:11]) == 2'h0) ? 5'h00 : (5'h02 << $past(lowcfg[12:11]))))
      else $error("channel 7 hysteresis decode wrong");

   chk_ch8_hysteresis: assert property ( // see R3
      RESETN_IN && $stable(lowcfg) |=>
      CH8_THR_OUT.hysteresis == (($past(lowcfg[20:19]) == 2'h0) ? 5'h00 : (5'h02 << $past(lowcfg[20:19]))))
      else $error("channel 8 hysteresis decode wrong");

   chk_write_answer: assert property ( // see R11
      wr_commit |=> AXI_BVALID_OUT)
      else $error("write committed without a response");

   chk_bresp_held: assert property ( // see R11
      AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
      else $error("write response dropped before taken");

   chk_rdata_held: assert property ( // see R5
      AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT) && $stable(AXI_RRESP_OUT))
      else $error("read response changed before taken");

   chk_read_latency: assert property ( // see R5
      RESETN_IN && AXI_ARVALID_IN && AXI_ARREADY_OUT |=> AXI_RVALID_OUT)
      else $error("read not answered next cycle");

   cov_startup_done: cover property ($rose(CORE_READY_OUT));
   cov_unlocked_write: cover property (wr_commit && aw_addr == mppl_pkg::LOWCFG_ADDR && unlocked);
   cov_back_to_back_read: cover property (AXI_RVALID_OUT && AXI_RREADY_IN ##1 AXI_ARVALID_IN);
   cov_status_pass: cover property (CORE_READY_OUT && STATUS_OUT != 8'h00);

endmodule // mppl_top

// >>> hdl/mppl_pkg.sv
// constants, carrier types and helper functions for the lower-threshold config and start-up block
package mppl_pkg;

   // register byte addresses
   localparam logic [7:0]  SEQ_CFG_ADDR    = 8'h00;
   localparam logic [7:0]  FILT_CFG_ADDR   = 8'h04;
   localparam logic [7:0]  CORE_STAT_ADDR  = 8'h08;
   localparam logic [7:0]  ACCESS_ADDR     = 8'h0c;
   localparam logic [7:0]  LOWCFG_ADDR     = 8'ha0;

   // lower-threshold config word: field positions
   localparam int          CH6_HYST_LSB    = 3;
   localparam int          CH6_CNT_LSB     = 0;
   localparam int          CH7_HYST_LSB    = 11;
   localparam int          CH7_CNT_LSB     = 8;
   localparam int          CH8_HYST_LSB    = 19;
   localparam int          CH8_CNT_LSB     = 16;

   // reset values and writable mask (reserved bits stay zero)
   localparam logic [31:0] LOWCFG_RESET    = 32'h000a0a0a;
   localparam logic [31:0] LOWCFG_MASK     = 32'h001f1f1f;
   localparam logic [9:0]  SEQ_RESET       = 10'h3ff;
   localparam logic [1:0]  COEF_RESET      = 2'h1;
   localparam logic        UNLOCK_RESET    = 1'b0;

   // field codes
   localparam logic [1:0]  NO_HYSTERESIS_CODE      = 2'h0;
   localparam logic [1:0]  HYSTERESIS_FOUR_CODE    = 2'h1;
   localparam logic [1:0]  HYSTERESIS_EIGHT_CODE   = 2'h2;
   localparam logic [1:0]  HYSTERESIS_SIXTEEN_CODE = 2'h3;
   localparam logic [2:0]  SINGLE_SAMPLE_CODE      = 3'h0;
   localparam logic [2:0]  MAX_SAMPLE_CODE         = 3'h7;

   // start-up: 2200 end-of-conversion events, forced sequence and coefficient
   localparam logic [11:0] STARTUP_EOCS    = 12'h898;
   localparam logic [9:0]  FORCED_SEQ      = 10'h3ff;
   localparam logic [1:0]  FASTEST_COEF    = 2'h0;  // code 0 is a = 2^-1

   // axi responses
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // per-channel decoded lower-threshold settings
   typedef struct packed {
      logic [4:0] hysteresis;
      logic [7:0] debounce;
   } mppl_chan_thr_t;

   // acquisition settings handed to the sequencer and filter
   typedef struct packed {
      logic [9:0] seq;
      logic [1:0] coef;
   } mppl_acq_cfg_t;

   // hysteresis amount from its two-bit select
   function automatic logic [4:0] hyst_value(input logic [1:0] code);
      unique case (code)
         NO_HYSTERESIS_CODE:      hyst_value = 5'h00;
         HYSTERESIS_FOUR_CODE:    hyst_value = 5'h04;
         HYSTERESIS_EIGHT_CODE:   hyst_value = 5'h08;
         HYSTERESIS_SIXTEEN_CODE: hyst_value = 5'h10;
      endcase
   endfunction

   // consecutive measurements from the three-bit select: 1 to 128
   function automatic logic [7:0] debounce_count(input logic [2:0] code);
      debounce_count = 8'h01 << code;
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      apply_strb = r;
   endfunction

endpackage

// >>> bench/mppl_top_tb.sv
// self-checking bench for the lower-threshold config and start-up block
`timescale 1ns/1ps
module mppl_top_tb;
   logic                      mclk = 1'b0;
   logic                      rstn = 1'b0;
   logic                      eoc = 1'b0;
   logic [7:0]                status_in = 8'h00;
   logic                      awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]                awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]               wdata = 32'h0;
   logic [3:0]                wstrb = 4'h0;
   logic                      awready, wready, bvalid, arready, rvalid, ready;
   logic [1:0]                bresp, rresp;
   logic [31:0]               rdata;
   logic [7:0]                status_out;
   mppl_pkg::mppl_acq_cfg_t   acq;
   mppl_pkg::mppl_chan_thr_t  ch6_thr, ch7_thr, ch8_thr;
   logic [31:0]               seed = 32'hbe2c;
   logic [1:0]                bq[$];
   logic [33:0]               rq[$];
   int                        error_cnt = 0;
   int                        total_checks = 0;

   // 250 mhz clock
   always #2 mclk = ~mclk;

   mppl_top i_dut (
      .MCLK_IN(mclk), .RESETN_IN(rstn), .EOC_IN(eoc), .STATUS_IN(status_in),
      .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready), .AXI_AWADDR_IN(awaddr),
      .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
      .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_BRESP_OUT(bresp),
      .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_ARADDR_IN(araddr),
      .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
      .CORE_READY_OUT(ready), .STATUS_OUT(status_out), .ACQ_CFG_OUT(acq),
      .CH6_THR_OUT(ch6_thr), .CH7_THR_OUT(ch7_thr), .CH8_THR_OUT(ch8_thr)
   );

   // xorshift source, fixed start so runs repeat
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // decoded setting worked out independently of the design helpers
   function automatic logic [12:0] thr(input logic [1:0] h, input logic [2:0] c);
      return {((h == 2'h0) ? 5'h00 : (5'h02 << h)), 8'h01 << c};
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      bq.push_back(er);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      rq.push_back({er, ed});
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
   endtask

   // monitor: oldest expectation is matched against each response as it is taken
   always @(posedge mclk) begin
      if (bvalid && bready) chk(64'(bresp), 64'(bq.pop_front()));
      if (rvalid && rready) chk(64'({rresp, rdata}), 64'(rq.pop_front()));
   end

   // watchdog, well beyond the expected few thousand cycles
   initial begin
      repeat (30000) @(posedge mclk);
      error_cnt++;
      conclude();
   end

   task automatic do_reset();
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
   endtask

   initial begin
      logic [31:0] w;
      logic [2:0]  c;
      logic [7:0]  s;
      int          n;
      do_reset();
      // reset values, and the lock on the internal channel word
      rd(mppl_pkg::LOWCFG_ADDR, 32'h000a0a0a, mppl_pkg::RESP_OKAY);
      rd(mppl_pkg::SEQ_CFG_ADDR, 32'h3ff, mppl_pkg::RESP_OKAY);
      rd(mppl_pkg::FILT_CFG_ADDR, 32'h1, mppl_pkg::RESP_OKAY);
      rd(mppl_pkg::ACCESS_ADDR, 32'h0, mppl_pkg::RESP_OKAY);
      chk(64'(ch7_thr), 64'(thr(2'h1, 3'h2)));
      wr(mppl_pkg::LOWCFG_ADDR, 32'h001f1f1f, 4'hf, mppl_pkg::RESP_SLVERR);
      rd(mppl_pkg::LOWCFG_ADDR, 32'h000a0a0a, mppl_pkg::RESP_OKAY);
      wr(mppl_pkg::CORE_STAT_ADDR, 32'h1, 4'hf, mppl_pkg::RESP_SLVERR);
      rd(8'h10, 32'h0, mppl_pkg::RESP_SLVERR);
      rd(8'ha1, 32'h0, mppl_pkg::RESP_SLVERR);
      $display("test reset_and_lock done");
      // every hysteresis and debounce code on each channel, junk in reserved bits
      wr(mppl_pkg::ACCESS_ADDR, 32'h1, 4'hf, mppl_pkg::RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         w = (rnd() & ~mppl_pkg::LOWCFG_MASK)
             | {11'h0, c[1:0] + 2'h1, c + 3'h3, 3'h0, ~c[1:0], ~c, 3'h0, c[1:0], c};
         wr(mppl_pkg::LOWCFG_ADDR, w, 4'hf, mppl_pkg::RESP_OKAY);
         rd(mppl_pkg::LOWCFG_ADDR, w & 32'h001f1f1f, mppl_pkg::RESP_OKAY);
         chk(64'(ch6_thr), 64'(thr(c[1:0], c)));
         chk(64'(ch7_thr), 64'(thr(~c[1:0], ~c)));
         chk(64'(ch8_thr), 64'(thr(c[1:0] + 2'h1, c + 3'h3)));
      end
      // byte lane two only touches the channel 8 fields
      wr(mppl_pkg::LOWCFG_ADDR, 32'hffffffff, 4'h4, mppl_pkg::RESP_OKAY);
      rd(mppl_pkg::LOWCFG_ADDR, (w & 32'h00001f1f) | 32'h001f0000, mppl_pkg::RESP_OKAY);
      chk(64'(ch8_thr), 64'(thr(2'h3, 3'h7)));
      $display("test field_codes done");
      // programmed settings must stay hidden until start-up ends
      wr(mppl_pkg::SEQ_CFG_ADDR, 32'h155, 4'hf, mppl_pkg::RESP_OKAY);
      wr(mppl_pkg::FILT_CFG_ADDR, 32'h3, 4'hf, mppl_pkg::RESP_OKAY);
      rd(mppl_pkg::CORE_STAT_ADDR, 32'h0, mppl_pkg::RESP_OKAY);
      n = 0;
      while (n < 2200) begin
         @(posedge mclk);
         chk(64'(ready), 64'(1'b0));
         chk(64'(status_out), 64'(8'h00));
         chk(64'(acq), 64'({10'h3ff, 2'h0}));
         if (eoc) n++;
         w = rnd();
         eoc <= w[0] | w[1];
         status_in <= w[15:8] | 8'h01;
      end
      // first ready cycle: status still forced
      @(posedge mclk);
      chk(64'(ready), 64'(1'b1));
      chk(64'(status_out), 64'(8'h00));
      s = status_in;
      eoc <= 1'b1;
      w = rnd();
      status_in <= w[15:8];
      repeat (6) begin
         @(posedge mclk);
         chk(64'(status_out), 64'(s));
         chk(64'(acq), 64'({10'h155, 2'h3}));
         chk(64'(ready), 64'(1'b1));
         s = status_in;
         w = rnd();
         status_in <= w[15:8];
      end
      // count frozen at 2200 although events keep coming
      rd(mppl_pkg::CORE_STAT_ADDR, 32'h00001131, mppl_pkg::RESP_OKAY);
      $display("test startup done");
      // a second reset starts a fresh start-up phase
      do_reset();
      @(posedge mclk);
      chk(64'(ready), 64'(1'b0));
      chk(64'(acq), 64'({10'h3ff, 2'h0}));
      chk(64'(status_out), 64'(8'h00));
      rd(mppl_pkg::LOWCFG_ADDR, 32'h000a0a0a, mppl_pkg::RESP_OKAY);
      rd(mppl_pkg::ACCESS_ADDR, 32'h0, mppl_pkg::RESP_OKAY);
      $display("test second_reset done");
      repeat (2) @(posedge mclk);
      conclude();
   end
endmodule // mppl_top_tb
